// ===== src/ccfs_supervisor.sv
// Control checksum and fault supervisor: register file behind the control port,
// CRC and XOR checksums, sticky faults, Hi-Z forcing and shutdown ramp.
// Assumes a serial control engine delivers one-cycle decoded byte accesses.
`timescale 1ns/1ps
`include "ccfs_map.svh"

module ccfs_supervisor
	import ccfs_pkg::*;
#(
	parameter int unsigned DC_PERSIST_CYC = `CCFS_DC_MS * 1000 * `CCFS_CLK_MHZ
) (
	input  wire logic                        clk,            // 25 MHz clock
	input  wire logic                        rst_n,          // Sync reset, active low
	input  wire logic                        ce,             // Freezes all state when low
	input  wire logic                        power_down_pin, // Low forces deep sleep
	input  wire ccfs_pkg::ccfs_req_type      req,            // Decoded register access
	input  wire ccfs_pkg::ccfs_fault_in_type fin,            // Live detector levels
	input  wire logic [7:0]                  sample_rate_in, // Live sample rate monitor
	input  wire logic                        sample_tick,    // One pulse per sample
	input  wire logic                        autorecover_en, // Over-temp auto recovery
	output logic      [7:0]                  rdata_ff,       // Read data
	output logic                             rvalid_ff,      // Read data valid pulse
	output ccfs_pkg::ccfs_state_type         dev_state_ff,   // Applied device state
	output logic                             stage_hiz,      // Output stage not playing
	output logic      [1:0]                  chan_off_ff,    // Channel disabled
	output logic      [1:0]                  cur_limit_ff,   // Peak limiter active
	output logic      [7:0]                  vol_out_ff,     // Applied attenuation code
	output logic                             ramp_busy_ff,   // Shutdown ramp running
	output logic                             fault_o,        // Fault pin output level
	output logic                             fault_oe_n_ff   // Fault pin enable, low drives
);
	import ccfs_pkg::*;

	localparam int unsigned OCSHUT_CYC = `CCFS_OCSHUT_NS / `CCFS_CLK_NS;

	////////////////////////////////////////////////////////////////////////////////
	// Book and page tracking, access decode

	logic [7:0] page_ff;
	logic [7:0] book_ff;
	logic [7:0] ctrl_ff;
	logic [7:0] vol_ff;
	logic [7:0] rampc_ff;
	logic [7:0] crc_ff;
	logic [7:0] xor_ff;
	logic [7:0] crc_calc;
	logic [3:0] chf_ff;
	logic [2:0] gfa_ff;
	logic       gfb_ff;
	logic [7:0] ramp_lvl_ff;
	logic [1:0] dc_expired;

	wire on_p0    = (page_ff == 8'h00);
	wire b0p0     = on_p0 && (book_ff == 8'h00);
	wire page_wr  = req.wr && (req.addr == `CCFS_PAGE_SEL);
	wire book_wr  = req.wr && on_p0 && (req.addr == `CCFS_BOOK_SEL);
	wire crc_hit  = on_p0 && (req.addr == `CCFS_CRC_OFF);
	wire xor_hit  = on_p0 && (book_ff == `CCFS_XOR_BOOK) && (req.addr == `CCFS_XOR_OFF);
	wire crc_zero = req.wr && crc_hit && (req.data == 8'h00);
	wire xor_zero = req.wr && xor_hit && (req.data == 8'h00);
	wire crc_acc  = req.wr && !page_wr && !book_wr;
	wire xor_acc  = req.wr && !page_wr && !on_p0 && (book_ff == `CCFS_XOR_BOOK);
	wire reg_wr   = req.wr && b0p0;
	wire clr_now  = reg_wr && (req.addr == `CCFS_FCLR_OFF);

	ccfs_crc8 u_crc (
		.crc_in  (crc_ff),
		.byte_in (req.data),
		.crc_out (crc_calc)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			page_ff <= 8'h00;
			book_ff <= 8'h00;
		end else if (ce) begin
			// Book only moves from page 0; elsewhere offset 0x7f is ordinary
			if (page_wr)
				page_ff <= req.data;
			if (book_wr)
				book_ff <= req.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checksums

	wire [7:0] nxt_crc = crc_zero ? 8'h00 : (crc_acc ? crc_calc : crc_ff);
	wire [7:0] nxt_xor = xor_zero ? 8'h00 : (xor_acc ? (xor_ff ^ req.data) : xor_ff);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			crc_ff <= 8'h00;
			xor_ff <= 8'h00;
		end else if (ce) begin
			// Only writes feed the sums, mapped or not
			crc_ff <= nxt_crc;
			xor_ff <= nxt_xor;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_ff  <= `CCFS_CTRL_RST;
			vol_ff   <= `CCFS_VOL_RST;
			rampc_ff <= `CCFS_RAMP_RST;
		end else if (ce && reg_wr) begin
			if (req.addr == `CCFS_CTRL_OFF)
				ctrl_ff <= req.data;
			if (req.addr == `CCFS_VOL_OFF)
				vol_ff <= req.data;
			if (req.addr == `CCFS_RAMP_OFF)
				rampc_ff <= req.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fault latches

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_dc
			ccfs_persist_timer #(.LIMIT(DC_PERSIST_CYC)) u_dc (
				.clk        (clk),
				.rst_n      (rst_n),
				.ce         (ce),
				.cond       (fin.dc_offset[ch]),
				.expired_ff (dc_expired[ch])
			);
		end
	endgenerate

	wire       clk_err = fin.clk_halt | fin.ratio_err | fin.pll_unlock | fin.fs_err;
	wire [3:0] chf_set = {dc_expired, fin.oc_shutdown};
	wire [2:0] gfa_set = {clk_err, fin.overvolt, fin.undervolt};

	// Clear wins for its own cycle; a standing fault is back one cycle later
	wire [3:0] nxt_chf = clr_now ? 4'h0 : (chf_ff | chf_set);
	wire [2:0] nxt_gfa = clr_now ? 3'h0 : (gfa_ff | gfa_set);
	wire       nxt_gfb = clr_now ? 1'b0 : (gfb_ff | fin.overtemp);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chf_ff <= 4'h0;
			gfa_ff <= 3'h0;
			gfb_ff <= 1'b0;
		end else if (ce) begin
			chf_ff <= nxt_chf;
			gfa_ff <= nxt_gfa;
			gfb_ff <= nxt_gfb;
		end
	end

	// Over-current channel kill is one cycle, inside the 100 ns budget
	wire [1:0] nxt_off   = fin.oc_shutdown | chf_ff[1:0];
	// Live shutdown drives the pin even in a clear cycle
	wire       nxt_fault = (|nxt_chf) | (|fin.oc_shutdown);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chan_off_ff   <= 2'h0;
			cur_limit_ff  <= 2'h0;
			fault_oe_n_ff <= 1'b1;
		end else if (ce) begin
			chan_off_ff   <= nxt_off;
			cur_limit_ff  <= fin.oc_limit & ~fin.oc_shutdown;
			fault_oe_n_ff <= ~nxt_fault;
		end
	end
	assign fault_o = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Device state and shutdown ramp

	// Live supply and clock faults release Hi-Z by themselves; DC needs a clear
	wire ot_hold = fin.overtemp | (gfb_ff & ~autorecover_en);
	wire hiz_req = (|chf_ff[3:2]) | ot_hold | fin.overvolt | fin.undervolt | clk_err;
	wire ccfs_state_type target = !power_down_pin ? ST_DEEP : ccfs_state_type'(ctrl_ff[1:0]);
	wire ramp_done = (ramp_lvl_ff == `CCFS_VOL_MUTE);
	wire leaving   = (target != ST_PLAY) && !hiz_req;

	ccfs_state_type nxt_state;
	logic [7:0]     nxt_lvl;
	logic           nxt_busy;

	always_comb begin
		nxt_state = dev_state_ff;
		nxt_lvl   = ramp_lvl_ff;
		nxt_busy  = 1'b0;
		case (dev_state_ff)
			ST_PLAY: begin
				if (hiz_req) begin
					nxt_state = ST_HIZ;
					nxt_lvl   = `CCFS_VOL_MUTE;
				end else if (leaving) begin
					// Soft stop: one 0.5 dB step per sample, then leave play
					nxt_busy = !ramp_done;
					if (ramp_done)
						nxt_state = target;
					else if (sample_tick)
						nxt_lvl = ramp_lvl_ff + `CCFS_VOL_STEP;
				end else
					nxt_lvl = vol_ff;
			end
			ST_DEEP, ST_SLEEP, ST_HIZ: begin
				nxt_lvl = `CCFS_VOL_MUTE;
				if (target == ST_PLAY && !hiz_req) begin
					nxt_state = ST_PLAY;
					nxt_lvl   = vol_ff;
				end else if (target == ST_PLAY)
					nxt_state = ST_HIZ;
				else
					nxt_state = target;
			end
			default: begin
				nxt_state = ST_DEEP;
				nxt_lvl   = `CCFS_VOL_MUTE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dev_state_ff <= ST_DEEP;
			ramp_lvl_ff  <= `CCFS_VOL_MUTE;
			vol_out_ff   <= `CCFS_VOL_MUTE;
			ramp_busy_ff <= 1'b0;
		end else if (ce) begin
			dev_state_ff <= nxt_state;
			ramp_lvl_ff  <= nxt_lvl;
			vol_out_ff   <= nxt_lvl;
			ramp_busy_ff <= nxt_busy;
		end
	end
	assign stage_hiz = (dev_state_ff != ST_PLAY);

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	wire [7:0] clkdet = {4'h0, fin.pll_unlock, fin.ratio_err, fin.clk_halt, fin.fs_err};
	logic [7:0] rmux;

	always_comb begin
		rmux = 8'h00;
		if (req.addr == `CCFS_PAGE_SEL)
			rmux = page_ff;
		else if (on_p0 && req.addr == `CCFS_BOOK_SEL)
			rmux = book_ff;
		else if (crc_hit)
			rmux = crc_ff;
		else if (xor_hit)
			rmux = xor_ff;
		else if (b0p0) begin
			case (req.addr)
				`CCFS_CTRL_OFF:   rmux = ctrl_ff;
				`CCFS_FSMON_OFF:  rmux = sample_rate_in;
				`CCFS_CLKDET_OFF: rmux = clkdet;
				`CCFS_VOL_OFF:    rmux = vol_ff;
				`CCFS_RAMP_OFF:   rmux = rampc_ff;
				`CCFS_CHF_OFF:    rmux = {4'h0, chf_ff};
				`CCFS_GFA_OFF:    rmux = {5'h00, gfa_ff};
				`CCFS_GFB_OFF:    rmux = {7'h00, gfb_ff};
				default:          rmux = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end else if (ce) begin
			rvalid_ff <= req.rd && !req.wr;
			if (req.rd && !req.wr)
				rdata_ff <= rmux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_dc_latched;
		ce && chf_ff[2] && !clr_now ##1 ce;
	endsequence

	crc_zeroing_a: assert property (ce && crc_zero |=> crc_ff == 8'h00)
		else $error("crc not zeroed");
	crc_switch_a: assert property (ce && (page_wr || book_wr) |=> $stable(crc_ff))
		else $error("page or book switch moved crc");
	xor_update_a: assert property (ce && xor_acc && !xor_zero |=>
		xor_ff == ($past(xor_ff) ^ $past(req.data)))
		else $error("xor checksum wrong");
	xor_scope_a: assert property (ce && req.wr && book_ff != `CCFS_XOR_BOOK |=> $stable(xor_ff))
		else $error("xor moved outside its book");
	read_quiet_a: assert property (ce && req.rd && !req.wr |=> $stable(crc_ff) && $stable(xor_ff))
		else $error("read changed a checksum");
	oc_kill_a: assert property (ce && fin.oc_shutdown[0] |=> chan_off_ff[0] && !fault_oe_n_ff)
		else $error("channel not disabled on over-current");
	oc_chan1_a: assert property (ce && fin.oc_shutdown[1] |->
		##[1:OCSHUT_CYC] chan_off_ff[1])
		else $error("channel 1 not disabled in time");
	dc_hiz_hold_a: assert property (s_dc_latched |-> chf_ff[2] && dev_state_ff != ST_PLAY)
		else $error("dc fault released without clear");
	ov_sticky_a: assert property (ce && gfa_ff[`CCFS_GFA_OV] && !clr_now |=> gfa_ff[`CCFS_GFA_OV])
		else $error("over-voltage bit dropped");
	clock_hiz_a: assert property (ce && clk_err && !clr_now |=>
		dev_state_ff != ST_PLAY && gfa_ff[`CCFS_GFA_CLK])
		else $error("clock error did not force hi-z");
	clear_all_a: assert property (ce && clr_now |=> chf_ff == 4'h0 && gfa_ff == 3'h0 && !gfb_ff)
		else $error("fault clear incomplete");
	ramp_step_a: assert property (ce && dev_state_ff == ST_PLAY && leaving && !ramp_done
		&& sample_tick |=> ramp_lvl_ff == $past(ramp_lvl_ff) + `CCFS_VOL_STEP)
		else $error("ramp step wrong");
	uv_resume_a: assert property (ce && dev_state_ff == ST_HIZ && target == ST_PLAY && !hiz_req
		|=> dev_state_ff == ST_PLAY)
		else $error("no automatic return to play");

endmodule // ccfs_supervisor

// ===== src/ccfs_map.svh
// Register offsets, field positions, reset values and timing counts
// Included by the supervisor package users; definitions only
`ifndef CCFS_MAP_SVH
`define CCFS_MAP_SVH

`define CCFS_PAGE_SEL    8'h00
`define CCFS_BOOK_SEL    8'h7f
`define CCFS_XOR_BOOK    8'h8c
`define CCFS_CTRL_OFF    8'h03
`define CCFS_FSMON_OFF   8'h37
`define CCFS_CLKDET_OFF  8'h39
`define CCFS_VOL_OFF     8'h4c
`define CCFS_RAMP_OFF    8'h4e
`define CCFS_CHF_OFF     8'h70
`define CCFS_GFA_OFF     8'h71
`define CCFS_GFB_OFF     8'h72
`define CCFS_FCLR_OFF    8'h78
`define CCFS_XOR_OFF     8'h7d
`define CCFS_CRC_OFF     8'h7e

`define CCFS_CTRL_RST    8'h10
`define CCFS_VOL_RST     8'h00
`define CCFS_RAMP_RST    8'h00
`define CCFS_CRC_POLY    8'h07
`define CCFS_VOL_MUTE    8'hff
`define CCFS_VOL_STEP    8'h01

`define CCFS_CHF_OC_LSB  0
`define CCFS_CHF_DC_LSB  2
`define CCFS_GFA_UV      0
`define CCFS_GFA_OV      1
`define CCFS_GFA_CLK     2
`define CCFS_GFB_OT      0

`define CCFS_CLK_NS      40
`define CCFS_CLK_MHZ     25
`define CCFS_OCSHUT_NS   100
`define CCFS_DC_MS       570

`endif

// ===== src/ccfs_pkg.sv
// Types shared by the control checksum and fault supervisor
// Assumes the serial control engine outside delivers decoded byte accesses
package ccfs_pkg;

	typedef enum logic [1:0] {
		ST_DEEP  = 2'b00,
		ST_SLEEP = 2'b01,
		ST_HIZ   = 2'b10,
		ST_PLAY  = 2'b11
	} ccfs_state_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] data;
	} ccfs_req_type;

	typedef struct packed {
		logic [1:0] oc_shutdown;
		logic [1:0] oc_limit;
		logic [1:0] dc_offset;
		logic       overtemp;
		logic       overvolt;
		logic       undervolt;
		logic       clk_halt;
		logic       ratio_err;
		logic       pll_unlock;
		logic       fs_err;
	} ccfs_fault_in_type;

endpackage

// ===== src/ccfs_crc8.sv
// One-byte step of the 8-bit control checksum CRC
// Purely combinational; the caller holds the running value
`timescale 1ns/1ps
`include "ccfs_map.svh"

module ccfs_crc8 (
	input  wire logic [7:0] crc_in,   // Running value
	input  wire logic [7:0] byte_in,  // Written byte
	output logic      [7:0] crc_out   // Value after this byte
);
	logic [7:0] stage [0:8];

	assign stage[0] = crc_in ^ byte_in;
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_shift
			// Msb first, no final inversion
			assign stage[i+1] = stage[i][7] ?
				({stage[i][6:0], 1'b0} ^ `CCFS_CRC_POLY) :
				{stage[i][6:0], 1'b0};
		end
	endgenerate
	assign crc_out = stage[8];
endmodule // ccfs_crc8

// ===== src/ccfs_persist_timer.sv
// Persistence timer: flags a condition held for LIMIT enabled cycles
// Assumes cond is synchronous to clk
`timescale 1ns/1ps

module ccfs_persist_timer #(
	parameter int unsigned LIMIT = 16
) (
	input  wire logic clk,        // Clock
	input  wire logic rst_n,      // Sync reset, active low
	input  wire logic ce,         // Clock enable
	input  wire logic cond,       // Condition to time
	output logic      expired_ff  // Held long enough
);
	localparam logic [23:0] LIM = 24'(LIMIT);
	logic [23:0] cnt_ff;
	logic [23:0] nxt_cnt;

	// Any gap in the condition restarts the count
	assign nxt_cnt = !cond ? 24'h000000 : ((cnt_ff == LIM) ? cnt_ff : cnt_ff + 24'h000001);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_ff     <= 24'h000000;
			expired_ff <= 1'b0;
		end else if (ce) begin
			cnt_ff     <= nxt_cnt;
			expired_ff <= (nxt_cnt == LIM);
		end
	end

	persist_expire_a: assert property (@(posedge clk) disable iff (!rst_n)
		ce && cond && cnt_ff == LIM - 24'h000001 |=> expired_ff)
		else $error("persistence timer did not expire");
endmodule // ccfs_persist_timer

// ===== dv/ccfs_host_model.sv
// Host controller model: drives decoded byte accesses and the power-down pin
// Assumes the bench calls its tasks and keeps book and page bookkeeping itself
`timescale 1ns/1ps
module ccfs_host_model (
	input  wire logic          clk,            // Bench clock
	output ccfs_pkg::ccfs_req_type req,        // Decoded register access
	output logic               power_down_pin, // Pin level
	input  wire logic [7:0]    rdata_ff,       // Read data
	input  wire logic          rvalid_ff       // Read valid pulse
);
	import ccfs_pkg::*;
	initial begin
		req = '0;
		power_down_pin = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Released lines show the inverse so a stale value never passes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic v);
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
		@(negedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hff};
		q = rdata_ff;
		v = rvalid_ff;
	endtask
	// Raised only once supplies are up; dropped to shut down
	task automatic set_pin(input logic v);
		@(negedge clk);
		power_down_pin <= v;
	endtask
endmodule // ccfs_host_model

// ===== dv/control_checksum_fault_supervisor_bench.sv
// Self-checking bench for the checksum and fault supervisor
// Assumes the host model drives the register port and the pin
`timescale 1ns/1ps
module control_checksum_fault_supervisor_bench;
	import ccfs_pkg::*;
	localparam int DCC = 20;
	logic           clk = 1'b0;
	logic           rst_n = 1'b0;
	logic           tick = 1'b0;
	logic           auto_en = 1'b0;
	logic           ce_in = 1'b1;
	logic [12:0]    fb = '0;
	logic [7:0]     fsm, vol, rdata, d;
	logic           pin, rvalid, hiz, oe_n, busy, fo;
	logic [1:0]     coff, clim;
	ccfs_req_type   req;
	ccfs_state_type st;
	logic [7:0]     lv [6] = '{8'h01, 8'h08, 8'h04, 8'h02, 8'h00, 8'h00};
	logic [7:0]     ga [6] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h01, 8'h02};
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int crc = 0;
	int xr = 0;
	int page = 0;
	int book = 0;
	always #20 clk = ~clk;
	ccfs_supervisor #(.DC_PERSIST_CYC(DCC)) u_dut (.clk(clk), .rst_n(rst_n), .ce(ce_in),
		.power_down_pin(pin), .req(req), .fin(ccfs_fault_in_type'(fb)), .sample_rate_in(fsm),
		.sample_tick(tick), .autorecover_en(auto_en), .rdata_ff(rdata), .rvalid_ff(rvalid),
		.dev_state_ff(st), .stage_hiz(hiz), .chan_off_ff(coff), .cur_limit_ff(clim),
		.vol_out_ff(vol), .ramp_busy_ff(busy), .fault_o(fo), .fault_oe_n_ff(oe_n));
	ccfs_host_model u_host (.clk(clk), .req(req), .power_down_pin(pin),
		.rdata_ff(rdata), .rvalid_ff(rvalid));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic results();
		$display("comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic int step(int c, int b);
		c = (c ^ b) & 255;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ((c << 1) ^ 7) & 255 : (c << 1) & 255;
		return c;
	endfunction
	// Reference checksums follow the same book and page tracking as the supervisor
	task automatic bwr(input int a, input int v);
		if (a == 0)
			page = v;
		else if (page == 0 && a == 127)
			book = v;
		else begin
			crc = (page == 0 && a == 126 && v == 0) ? 0 : step(crc, v);
			if (book == 140 && page != 0)
				xr ^= v;
			if (book == 140 && page == 0 && a == 125 && v == 0)
				xr = 0;
		end
		u_host.wr(8'(a), 8'(v));
	endtask
	task automatic brd(input logic [7:0] a, input int e);
		logic [7:0] q;
		logic       ok;
		u_host.rd(a, q, ok);
		check({7'h00, ok}, 8'h01);
		check(q, 8'(e));
	endtask
	task automatic goto(input int b, input int p);
		bwr(0, 0);
		bwr(127, b);
		bwr(0, p);
	endtask
	// Sample ticks keep running so a shutdown ramp can finish
	task automatic wait_st(input ccfs_state_type s);
		for (int i = 0; i < 120 && st !== s; i++) begin
			@(negedge clk);
			tick = (i % 4 == 0);
		end
		tick = 1'b0;
		check(8'(st), 8'(s));
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h624c));
		fsm = 8'($urandom());
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		u_host.set_pin(1'b1);
		brd(8'h03, 8'h10);
		brd(8'h37, fsm);
		for (int i = 0; i < 4; i++)
			bwr(8'h4e, $urandom() & 255);
		brd(8'h7e, crc);
		brd(8'h7e, crc);
		goto(140, 0);
		brd(8'h7e, crc);
		goto(140, 5);
		for (int i = 0; i < 6; i++)
			bwr($urandom() % 126 + 1, $urandom() & 255);
		goto(140, 0);
		brd(8'h7d, xr);
		brd(8'h7e, crc);
		bwr(8'h7d, 0);
		brd(8'h7d, 8'h00);
		bwr(8'h7e, 0);
		brd(8'h7e, 8'h00);
		goto(0, 0);
		bwr(8'h4c, 8'hf0);
		bwr(8'h03, 8'h03);
		wait_st(ST_PLAY);
		check(vol, 8'hf0);
		bwr(8'h03, 8'h00);
		d = 8'h00;
		for (int i = 0; i < 200 && st !== ST_DEEP; i++) begin
			@(negedge clk);
			tick = (i % 4 == 0) && busy;
			if (tick)
				d++;
		end
		tick = 1'b0;
		check(d, 8'h0f);
		check(vol, 8'hff);
		check(8'(st), 8'(ST_DEEP));
		bwr(8'h03, 8'h03);
		wait_st(ST_PLAY);
		for (int k = 0; k < 6; k++) begin
			fb = 13'h0001 << k;
			repeat (3) @(negedge clk);
			check(8'(hiz), 8'h01);
			brd(8'h39, lv[k]);
			brd(8'h71, ga[k]);
			fb = '0;
			wait_st(ST_PLAY);
			brd(8'h71, ga[k]);
			bwr(8'h78, $urandom() & 255);
			brd(8'h71, 8'h00);
		end
		fb = 13'h0040;
		repeat (3) @(negedge clk);
		fb = '0;
		repeat (3) @(negedge clk);
		check(8'(hiz), 8'h01);
		brd(8'h72, 8'h01);
		bwr(8'h78, 8'h01);
		wait_st(ST_PLAY);
		auto_en = 1'b1;
		fb = 13'h0040;
		repeat (3) @(negedge clk);
		bwr(8'h78, 8'h01);
		brd(8'h72, 8'h01);
		fb = '0;
		wait_st(ST_PLAY);
		fb = 13'h1800;
		@(negedge clk);
		fb = '0;
		check(8'(coff), 8'h03);
		check(8'(oe_n), 8'h00);
		brd(8'h70, 8'h03);
		bwr(8'h78, 8'h01);
		// Channel enable follows the cleared latch one cycle later
		@(negedge clk);
		check(8'(coff), 8'h00);
		brd(8'h70, 8'h00);
		fb = 13'h0400;
		repeat (2) @(negedge clk);
		check(8'(clim), 8'h02);
		check(8'(coff), 8'h00);
		fb = '0;
		repeat (2) @(negedge clk);
		check(8'(clim), 8'h00);
		brd(8'h70, 8'h00);
		fb = 13'h0080;
		repeat (DCC - 5) @(negedge clk);
		check(8'(hiz), 8'h00);
		repeat (10) @(negedge clk);
		check(8'(hiz), 8'h01);
		check(8'(oe_n), 8'h00);
		fb = '0;
		brd(8'h70, 8'h04);
		repeat (5) @(negedge clk);
		check(8'(hiz), 8'h01);
		bwr(8'h78, 8'h01);
		wait_st(ST_PLAY);
		// Frozen clock enable must ignore a supply fault entirely
		ce_in = 1'b0;
		fb = 13'h0020;
		repeat (3) @(negedge clk);
		check(8'(hiz), 8'h00);
		fb = '0;
		ce_in = 1'b1;
		brd(8'h71, 8'h00);
		bwr(8'h03, 8'h01);
		wait_st(ST_SLEEP);
		bwr(8'h03, 8'h03);
		wait_st(ST_PLAY);
		u_host.set_pin(1'b0);
		wait_st(ST_DEEP);
		results();
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end
endmodule // control_checksum_fault_supervisor_bench
